// file: hw/dcb_consts.svh
// constants for the dc braking and frequency limit block
`ifndef DCB_CONSTS_SVH
`define DCB_CONSTS_SVH
`define DCB_ADR_CTRL 6'h00
`define DCB_ADR_BFREQ 6'h04
`define DCB_ADR_DELAY 6'h08
`define DCB_ADR_POWER 6'h0c
`define DCB_ADR_TIME 6'h10
`define DCB_ADR_CARR 6'h14
`define DCB_ADR_LIM 6'h18
`define DCB_ADR_ALTLIM 6'h1c
`define DCB_ADR_STAT 6'h20
`define DCB_SEL_OFF 2'h0
`define DCB_SEL_AUTO 2'h1
`define DCB_SEL_THR 2'h2
`define DCB_CTRL_RST 32'h0000_0004
`define DCB_BFREQ_RST 16'h0005
`define DCB_DELAY_MAX 16'h0032
`define DCB_PWR_SMALL_RST 8'h32
`define DCB_PWR_LARGE_RST 8'h28
`define DCB_PWR_SMALL_MAX 8'h64
`define DCB_PWR_LARGE_MAX 8'h50
`define DCB_TIME_RST 16'h0005
`define DCB_TIME_MAX 16'h0258
`define DCB_CARR_RST 16'h0032
`define DCB_CARR_MIN 16'h0005
`define DCB_CARR_SMALL_MAX 16'h0096
`define DCB_CARR_LARGE_MAX 16'h0064
`define DCB_CARR_DERATE 16'h0032
`define DCB_CARR_DERATE2 16'h0064
`define DCB_RELEASE_HYST 16'h0014
`define DCB_TENTH_NS 100000000
`define DCB_CLK_NS 100
`define DCB_TENTH_CYCLES (`DCB_TENTH_NS / `DCB_CLK_NS)
`endif

// file: hw/dcb_pkg.sv
// types for the dc braking and frequency limit block
package dcb_pkg;
    typedef enum logic [1:0] {
        DCB_ST_NORMAL = 2'b00,
        DCB_ST_COAST = 2'b01,
        DCB_ST_BRAKE = 2'b10
    } dcb_state_e;
    typedef enum logic [1:0] {
        DCB_K_EXT = 2'b00,
        DCB_K_STOP = 2'b01,
        DCB_K_START = 2'b10
    } dcb_kind_e;
    typedef logic [15:0] dcb_freq_t;
endpackage : dcb_pkg

// file: hw/dcb_brake_limit.sv
// dc injection braking sequencer and output frequency limiter
`timescale 1ns/1ps
`include "dcb_consts.svh"
// Function
// - brake input terminal brakes unless selection is threshold
// - non-start braking uses general power, model range
// - nonzero delay coasts output before terminal and stop braking
// - method bit selects edge or level, level default
// - braking duration setting 0 to 60 s
// - selection auto brakes at start and stop
// - start braking uses own power and time
// - stop brake at or below braking frequency after run off
// - edge mode finishes full duration despite run
// - level mode aborts stop braking when run returns
// - threshold mode brakes when run and both below
// - threshold mode releases when reference reaches braking frequency plus 2 Hz
// - threshold mode disables terminal and auto braking
// - threshold start zero ref brakes, high ref runs
// - carrier range per model, derate from 5 kHz
// - reference clamped into the limit band
// - zero limit disables it; third set bypasses
// - alternate limit set while its input is on
// - minimum analog reference gives lower limit output
// - bipolar zero lower limit direction from source
module dcb_brake_limit #(
    parameter bit LARGE_MODEL = 1'b0,
    parameter int TENTH_CYCLES = `DCB_TENTH_CYCLES
) (
    input wire logic clk_i, // 10 mhz control clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic [5:0] wb_adr_i, // wishbone byte address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    input wire logic [3:0] wb_sel_i, // wishbone byte enables
    input wire logic wb_we_i, // wishbone write
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic run_forward_i, // forward run terminal, pin
    input wire logic run_reverse_i, // reverse run terminal, pin
    input wire logic brake_input_i, // brake input terminal, pin
    input wire logic alt_set_i, // alternate set terminal, pin
    input wire logic third_set_select_i, // third set terminal, pin
    input wire dcb_pkg::dcb_freq_t freq_ref_i, // reference, 0.1 hz
    input wire logic ref_bipolar_i, // reference from bipolar input
    input wire logic ref_neg_i, // bipolar reference is negative
    input wire dcb_pkg::dcb_freq_t out_freq_i, // present output, 0.1 hz
    output dcb_pkg::dcb_freq_t freq_cmd_o, // limited frequency command
    output logic dir_rev_o, // reverse rotation command
    output logic drive_en_o, // normal output active
    output logic dc_brake_o, // dc injection active
    output logic [7:0] brake_power_o // dc braking power, percent
);
    import dcb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    function automatic logic [7:0] derate(input logic [7:0] p, input logic [15:0] carr);
        logic [7:0] r;
        r = p;
        if (carr >= `DCB_CARR_DERATE2) begin
            r = p >> 1;
        end else if (carr >= `DCB_CARR_DERATE) begin
            r = p - (p >> 2);
        end
        return r;
    endfunction : derate

    function automatic logic [7:0] pclamp(input logic [7:0] p);
        logic [7:0] mx;
        mx = LARGE_MODEL ? `DCB_PWR_LARGE_MAX : `DCB_PWR_SMALL_MAX;
        return (p > mx) ? mx : p;
    endfunction : pclamp

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone registers
    logic [31:0] ctrl_q, bfreq_q, delay_q, power_q, time_q, carr_q, lim_q, altlim_q;
    logic ack_q;
    logic [31:0] rdat_q;
    dcb_state_e st_q;
    dcb_kind_e kind_q;
    logic thr_brake_q;
    logic [7:0] eff_pwr;
    wire acc = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr = acc && wb_we_i;
    // status word: derated power, threshold flag, sequencer state
    wire [31:0] stat_w = {20'h0, eff_pwr, 1'b0, thr_brake_q, st_q};
    logic [31:0] rmux;
    always_comb begin
        case (wb_adr_i)
            `DCB_ADR_CTRL: rmux = ctrl_q;
            `DCB_ADR_BFREQ: rmux = bfreq_q;
            `DCB_ADR_DELAY: rmux = delay_q;
            `DCB_ADR_POWER: rmux = power_q;
            `DCB_ADR_TIME: rmux = time_q;
            `DCB_ADR_CARR: rmux = carr_q;
            `DCB_ADR_LIM: rmux = lim_q;
            `DCB_ADR_ALTLIM: rmux = altlim_q;
            `DCB_ADR_STAT: rmux = stat_w;
            default: rmux = 32'h0;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `DCB_CTRL_RST;
            bfreq_q <= {16'h0, `DCB_BFREQ_RST};
            delay_q <= 32'h0;
            power_q <= {24'h0, LARGE_MODEL ? `DCB_PWR_LARGE_RST : `DCB_PWR_SMALL_RST};
            time_q <= {16'h0, `DCB_TIME_RST};
            carr_q <= {16'h0, `DCB_CARR_RST};
            lim_q <= 32'h0;
            altlim_q <= 32'h0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            ack_q <= acc;
            rdat_q <= (acc && !wb_we_i) ? rmux : 32'h0;
            if (wr && wb_adr_i == `DCB_ADR_CTRL) begin
                ctrl_q <= wmerge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_001f;
            end
            if (wr && wb_adr_i == `DCB_ADR_BFREQ) begin
                bfreq_q <= wmerge(bfreq_q, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
            end
            if (wr && wb_adr_i == `DCB_ADR_DELAY) begin
                delay_q <= wmerge(delay_q, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
            end
            if (wr && wb_adr_i == `DCB_ADR_POWER) begin
                power_q <= wmerge(power_q, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
            end
            if (wr && wb_adr_i == `DCB_ADR_TIME) begin
                time_q <= wmerge(time_q, wb_dat_i, wb_sel_i);
            end
            if (wr && wb_adr_i == `DCB_ADR_CARR) begin
                carr_q <= wmerge(carr_q, wb_dat_i, wb_sel_i) & 32'h0000_ffff;
            end
            if (wr && wb_adr_i == `DCB_ADR_LIM) begin
                lim_q <= wmerge(lim_q, wb_dat_i, wb_sel_i);
            end
            if (wr && wb_adr_i == `DCB_ADR_ALTLIM) begin
                altlim_q <= wmerge(altlim_q, wb_dat_i, wb_sel_i);
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [4:0] pin_m_q, pin_s_q;
    logic run_p_q, brk_p_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_m_q <= 5'h0;
            pin_s_q <= 5'h0;
            run_p_q <= 1'b0;
            brk_p_q <= 1'b0;
        end else begin
            pin_m_q <= {third_set_select_i, alt_set_i, brake_input_i, run_reverse_i,
                        run_forward_i};
            pin_s_q <= pin_m_q;
            run_p_q <= pin_s_q[0] | pin_s_q[1];
            brk_p_q <= pin_s_q[2];
        end
    end
    wire fw_s = pin_s_q[0];
    wire rv_s = pin_s_q[1];
    wire brk_s = pin_s_q[2];
    wire alt_s = pin_s_q[3];
    wire third_s = pin_s_q[4];
    wire run_s = fw_s | rv_s;

    ////////////////////////////////////////////////////////////////////////////////
    // settings
    wire [1:0] sel = ctrl_q[1:0];
    wire level = ctrl_q[2];
    wire src_panel = ctrl_q[3];
    wire panel_dir = ctrl_q[4];
    wire [15:0] bfreq = bfreq_q[15:0];
    wire [15:0] delay_t = (delay_q[15:0] > `DCB_DELAY_MAX) ? `DCB_DELAY_MAX : delay_q[15:0];
    wire [15:0] btime = (time_q[15:0] > `DCB_TIME_MAX) ? `DCB_TIME_MAX : time_q[15:0];
    wire [15:0] stime = (time_q[31:16] > `DCB_TIME_MAX) ? `DCB_TIME_MAX : time_q[31:16];
    wire [15:0] carr_max = LARGE_MODEL ? `DCB_CARR_LARGE_MAX : `DCB_CARR_SMALL_MAX;
    wire [15:0] carr = (carr_q[15:0] < `DCB_CARR_MIN) ? `DCB_CARR_MIN :
                       (carr_q[15:0] > carr_max) ? carr_max : carr_q[15:0];
    wire [7:0] pwr_gen = pclamp(power_q[7:0]);
    wire [7:0] pwr_start = pclamp(power_q[15:8]);
    wire [7:0] pwr_sel = (kind_q == DCB_K_START) ? pwr_start : pwr_gen;
    assign eff_pwr = derate(pwr_sel, carr);

    ////////////////////////////////////////////////////////////////////////////////
    // braking sequencer
    logic [15:0] cnt_q, cnt_d;
    logic [31:0] pre_q;
    logic stop_done_q;
    dcb_state_e st_d;
    dcb_kind_e kind_d;
    wire tick = (pre_q == 32'(TENTH_CYCLES - 1));
    wire ext_ok = (sel != `DCB_SEL_THR);
    wire auto_ok = (sel == `DCB_SEL_AUTO);
    wire ext_go = ext_ok && (level ? brk_s : (brk_s && !brk_p_q));
    wire stop_go = auto_ok && !run_s && !stop_done_q && (out_freq_i <= bfreq);
    wire start_go = auto_ok && run_s && !run_p_q && (stime != 16'h0);
    wire ext_lvl_end = (kind_q == DCB_K_EXT) && level && !brk_s;
    wire stop_abort = (kind_q == DCB_K_STOP) && level && run_s;
    always_comb begin
        st_d = st_q;
        kind_d = kind_q;
        cnt_d = (tick && cnt_q != 16'h0) ? cnt_q - 16'h1 : cnt_q;
        case (st_q)
            DCB_ST_NORMAL: begin
                if (ext_go || stop_go) begin
                    kind_d = ext_go ? DCB_K_EXT : DCB_K_STOP;
                    st_d = (delay_t != 16'h0) ? DCB_ST_COAST : DCB_ST_BRAKE;
                    cnt_d = (delay_t != 16'h0) ? delay_t : btime;
                end else if (start_go) begin
                    kind_d = DCB_K_START;
                    st_d = DCB_ST_BRAKE;
                    cnt_d = stime;
                end
            end
            DCB_ST_COAST: begin
                if (!ext_ok || ext_lvl_end || stop_abort) begin
                    st_d = DCB_ST_NORMAL;
                end else if (cnt_q == 16'h0) begin
                    st_d = DCB_ST_BRAKE;
                    cnt_d = btime;
                end
            end
            DCB_ST_BRAKE: begin
                if (!ext_ok || stop_abort) begin
                    st_d = DCB_ST_NORMAL;
                end else if (kind_q == DCB_K_EXT && level) begin
                    st_d = brk_s ? DCB_ST_BRAKE : DCB_ST_NORMAL;
                end else if (cnt_q == 16'h0) begin
                    st_d = DCB_ST_NORMAL;
                end
            end
            default: st_d = DCB_ST_NORMAL;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= DCB_ST_NORMAL;
            kind_q <= DCB_K_EXT;
            cnt_q <= 16'h0;
            pre_q <= 32'h0;
            stop_done_q <= 1'b1;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            pre_q <= (st_d != st_q || tick) ? 32'h0 : pre_q + 32'h1;
            if (run_s) begin
                stop_done_q <= 1'b0;
            end else if (st_q == DCB_ST_NORMAL && stop_go) begin
                stop_done_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frequency threshold braking
    wire thr_on = (sel == `DCB_SEL_THR) && run_s && freq_ref_i < bfreq && out_freq_i < bfreq;
    wire thr_off = (sel != `DCB_SEL_THR) || !run_s ||
                   ({1'b0, freq_ref_i} >= {1'b0, bfreq} + {1'b0, `DCB_RELEASE_HYST});
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_brake_q <= 1'b0;
        end else if (thr_off) begin
            thr_brake_q <= 1'b0;
        end else if (thr_on) begin
            thr_brake_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frequency limiter
    wire [31:0] lims = alt_s ? altlim_q : lim_q;
    wire [15:0] up_lim = lims[15:0];
    wire [15:0] lo_lim = lims[31:16];
    wire over = (up_lim != 16'h0) && (freq_ref_i > up_lim);
    wire under = (lo_lim != 16'h0) && (freq_ref_i < lo_lim);
    wire [15:0] lim_f = third_s ? freq_ref_i : over ? up_lim : under ? lo_lim : freq_ref_i;
    wire bip_zero = ref_bipolar_i && (freq_ref_i == 16'h0) && under && !third_s;
    wire src_rev = src_panel ? panel_dir : (rv_s && !fw_s);
    wire dir_d = bip_zero ? src_rev : (src_rev ^ (ref_bipolar_i && ref_neg_i));

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    wire brake_now = (st_q == DCB_ST_BRAKE) || thr_brake_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_cmd_o <= 16'h0;
            dir_rev_o <= 1'b0;
            drive_en_o <= 1'b0;
            dc_brake_o <= 1'b0;
            brake_power_o <= 8'h0;
        end else begin
            freq_cmd_o <= lim_f;
            dir_rev_o <= dir_d;
            drive_en_o <= run_s && (st_q == DCB_ST_NORMAL) && !thr_brake_q;
            dc_brake_o <= brake_now;
            brake_power_o <= brake_now ? (thr_brake_q ? derate(pwr_gen, carr) : eff_pwr) : 8'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_edge_brake;
        st_q == DCB_ST_BRAKE && !level && kind_q == DCB_K_STOP && cnt_q != 16'h0;
    endsequence
    property p_thr_no_fsm;
        sel == `DCB_SEL_THR |=> st_q == DCB_ST_NORMAL;
    endproperty
    a_thr_no_fsm: assert property (p_thr_no_fsm) else $error("fsm active in threshold mode");
    property p_ext_brake;
        (brk_s && !brk_p_q && ext_ok && st_q == DCB_ST_NORMAL) |=> st_q != DCB_ST_NORMAL;
    endproperty
    a_ext_brake: assert property (p_ext_brake) else $error("brake input ignored");
    property p_edge_keep;
        s_edge_brake ##0 run_s |=> st_q == DCB_ST_BRAKE;
    endproperty
    a_edge_keep: assert property (p_edge_keep) else $error("edge braking cut short");
    property p_level_abort;
        (st_q == DCB_ST_BRAKE && kind_q == DCB_K_STOP && level && run_s && ext_ok)
            |=> st_q == DCB_ST_NORMAL;
    endproperty
    a_level_abort: assert property (p_level_abort) else $error("level braking not aborted");
    property p_thr_release;
        thr_off |=> !thr_brake_q ##1 dc_brake_o == $past(st_q == DCB_ST_BRAKE);
    endproperty
    a_thr_release: assert property (p_thr_release) else $error("threshold brake held");
    property p_power_cap;
        dc_brake_o |-> brake_power_o <= pclamp(power_q[7:0]) ||
                       brake_power_o <= pclamp(power_q[15:8]);
    endproperty
    a_power_cap: assert property (p_power_cap) else $error("brake power above setting");
    property p_upper;
        (over && !third_s) |=> freq_cmd_o == $past(up_lim);
    endproperty
    a_upper: assert property (p_upper) else $error("upper limit not applied");
    property p_lower_zero;
        (lo_lim != 16'h0 && freq_ref_i == 16'h0 && !third_s) |=> freq_cmd_o == $past(lo_lim);
    endproperty
    a_lower_zero: assert property (p_lower_zero) else $error("zero ref not at lower limit");
    property p_third;
        third_s |=> freq_cmd_o == $past(freq_ref_i);
    endproperty
    a_third: assert property (p_third) else $error("limiter active in third set");
    property p_derate;
        (carr >= `DCB_CARR_DERATE && pwr_sel > 8'h3) |-> eff_pwr < pwr_sel;
    endproperty
    a_derate: assert property (p_derate) else $error("no derating at high carrier");
endmodule : dcb_brake_limit

// file: tb/dcb_plant.sv
// behavioural load model: output frequency follows the command while driven
`timescale 1ns/1ps
module dcb_plant #(
    parameter int STEP = 16
) (
    input wire logic clk_i, // control clock
    input wire logic rst_i, // synchronous reset
    input wire logic drive_en_i, // normal output active
    input wire logic [15:0] freq_cmd_i, // commanded frequency
    output logic [15:0] out_freq_o // present output frequency
);
    // ramps up toward the command while driven, drops straight to it when above, coasts down to standstill otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_freq_o <= 16'h0000;
        end else if (drive_en_i && out_freq_o + 16'(STEP) < freq_cmd_i) begin
            out_freq_o <= out_freq_o + 16'(STEP);
        end else if (drive_en_i) begin
            out_freq_o <= freq_cmd_i;
        end else begin
            out_freq_o <= (out_freq_o > 16'(STEP)) ? out_freq_o - 16'(STEP) : 16'h0000;
        end
    end
endmodule : dcb_plant

// file: tb/dcb_brake_limit_tb.sv
// self-checking bench for the dc braking and frequency limit block
`timescale 1ns/1ps
`include "dcb_consts.svh"
module dcb_brake_limit_tb;
    import dcb_pkg::*;
    localparam int TENTH = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [5:0] wb_adr = 6'h00;
    logic [31:0] wb_wdat = 32'h0;
    logic [3:0] wb_sel = 4'h0;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic run_fw = 1'b0;
    logic run_rv = 1'b0;
    logic brk_in = 1'b0;
    logic alt_set = 1'b0;
    logic third_set = 1'b0;
    logic ref_bip = 1'b0;
    logic ref_neg = 1'b0;
    dcb_freq_t freq_ref = 16'h0000;
    dcb_freq_t out_freq;
    dcb_freq_t freq_cmd;
    logic dir_rev;
    logic drive_en;
    logic dc_brake;
    logic [7:0] brk_pwr;
    logic [31:0] exp_q[$];
    logic [15:0] carr[3] = '{16'h0031, 16'h0032, 16'h0064};
    logic [7:0] pwr[3] = '{8'h32, 8'h26, 8'h19};
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 48762;
    dcb_freq_t r;
    dcb_freq_t lo;
    dcb_freq_t hi;

    always #50 clk_i = ~clk_i;

    dcb_brake_limit #(.LARGE_MODEL(1'b0), .TENTH_CYCLES(TENTH)) dcb_brake_limit_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
        .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .run_forward_i(run_fw),
        .run_reverse_i(run_rv), .brake_input_i(brk_in), .alt_set_i(alt_set),
        .third_set_select_i(third_set), .freq_ref_i(freq_ref), .ref_bipolar_i(ref_bip),
        .ref_neg_i(ref_neg), .out_freq_i(out_freq), .freq_cmd_o(freq_cmd),
        .dir_rev_o(dir_rev), .drive_en_o(drive_en), .dc_brake_o(dc_brake),
        .brake_power_o(brk_pwr));

    dcb_plant #(.STEP(16)) dcb_plant_i (.clk_i(clk_i), .rst_i(rst_i),
        .drive_en_i(drive_en), .freq_cmd_i(freq_cmd), .out_freq_o(out_freq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // one classic cycle: request held until ack is sampled, then released
    task automatic wb_xfer(input logic [5:0] adr, input logic we, input logic [31:0] dat,
                           input logic [3:0] sel);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_adr <= adr;
        wb_we <= we;
        wb_wdat <= dat;
        wb_sel <= sel;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        check("bus ack", wb_ack, 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb_xfer

    task automatic wb_wr(input logic [5:0] adr, input logic [31:0] dat);
        wb_xfer(adr, 1'b1, dat, 4'hf);
    endtask : wb_wr

    task automatic wb_rd(input logic [5:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb_xfer(adr, 1'b0, 32'h0, 4'hf);
    endtask : wb_rd

    task automatic wait_brake(input logic v);
        int n;
        n = 0;
        while (dc_brake !== v && n < 100) begin
            tick(1);
            n++;
        end
        check("brake wait", dc_brake, v);
    endtask : wait_brake

    // read data is compared against the oldest noted expectation
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            n_errors++;
            stop_test();
        end
        if (wb_ack === 1'b1 && !wb_we) begin
            check("read data", wb_rdat, exp_q.size() > 0 ? exp_q.pop_front() : 32'hxxxx_xxxx);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(5);
        rst_i <= 1'b0;
        check("brake after reset", dc_brake, 1'b0);
        check("drive after reset", drive_en, 1'b0);
        wb_rd(`DCB_ADR_CTRL, 32'h0000_0004);
        wb_rd(`DCB_ADR_BFREQ, 32'h0000_0005);
        wb_rd(`DCB_ADR_DELAY, 32'h0000_0000);
        wb_rd(`DCB_ADR_POWER, 32'h0000_0032);
        wb_rd(`DCB_ADR_TIME, 32'h0000_0005);
        wb_rd(`DCB_ADR_CARR, 32'h0000_0032);
        wb_wr(6'h24, 32'h1234_5678);
        wb_rd(6'h24, 32'h0000_0000);
        wb_wr(`DCB_ADR_POWER, 32'h0000_10ff);
        wb_rd(`DCB_ADR_POWER, 32'h0000_10ff);
        wb_xfer(`DCB_ADR_POWER, 1'b1, 32'hffff_ff32, 4'h1);
        wb_rd(`DCB_ADR_POWER, 32'h0000_1032);
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            wb_wr(`DCB_ADR_CARR, {16'h0000, carr[i]});
            brk_in <= 1'b1;
            tick(6);
            check("ext brake", dc_brake, 1'b1);
            check("ext drive off", drive_en, 1'b0);
            check("ext power", brk_pwr, pwr[i]);
            if (i == 1) begin
                wb_rd(`DCB_ADR_STAT, {20'h0, pwr[i], 4'h2});
            end
            tick(10 * TENTH);
            check("level hold", dc_brake, 1'b1);
            brk_in <= 1'b0;
            tick(6);
            check("ext release", dc_brake, 1'b0);
        end
        $display("test external level done");
        wb_wr(`DCB_ADR_CTRL, 32'h0000_0000);
        wb_wr(`DCB_ADR_DELAY, 32'h0000_0002);
        brk_in <= 1'b1;
        tick(2);
        brk_in <= 1'b0;
        tick(10);
        check("coast no brake", dc_brake, 1'b0);
        check("coast no drive", drive_en, 1'b0);
        tick(20);
        check("brake after delay", dc_brake, 1'b1);
        tick(30);
        check("edge brake lasts", dc_brake, 1'b1);
        tick(25);
        check("edge brake ends", dc_brake, 1'b0);
        $display("test delay and edge done");
        wb_wr(`DCB_ADR_DELAY, 32'h0000_0000);
        wb_wr(`DCB_ADR_CARR, 32'h0000_0031);
        wb_wr(`DCB_ADR_TIME, 32'h0002_0005);
        wb_wr(`DCB_ADR_CTRL, 32'h0000_0001);
        freq_ref <= 16'h0100;
        run_fw <= 1'b1;
        tick(6);
        check("start brake", dc_brake, 1'b1);
        check("start power", brk_pwr, 8'h10);
        tick(30);
        check("run after start", drive_en, 1'b1);
        tick(30);
        run_fw <= 1'b0;
        wait_brake(1'b1);
        check("stop power", brk_pwr, 8'h32);
        run_fw <= 1'b1;
        tick(10);
        check("edge keeps braking", dc_brake, 1'b1);
        tick(100);
        wb_wr(`DCB_ADR_TIME, 32'h0000_0005);
        wb_wr(`DCB_ADR_CTRL, 32'h0000_0005);
        tick(30);
        run_fw <= 1'b0;
        wait_brake(1'b1);
        run_fw <= 1'b1;
        tick(6);
        check("level back to run", drive_en, 1'b1);
        check("level brake cut", dc_brake, 1'b0);
        $display("test automatic done");
        wb_wr(`DCB_ADR_CTRL, 32'h0000_0006);
        run_fw <= 1'b0;
        brk_in <= 1'b1;
        tick(30);
        check("terminal ignored", dc_brake, 1'b0);
        brk_in <= 1'b0;
        freq_ref <= 16'h0000;
        run_fw <= 1'b1;
        tick(6);
        check("zero start brakes", dc_brake, 1'b1);
        freq_ref <= 16'h0018;
        tick(6);
        check("below release", dc_brake, 1'b1);
        freq_ref <= 16'h0019;
        tick(6);
        check("release", dc_brake, 1'b0);
        check("release drive", drive_en, 1'b1);
        run_fw <= 1'b0;
        freq_ref <= 16'h0100;
        tick(30);
        run_fw <= 1'b1;
        tick(6);
        check("high start runs", drive_en, 1'b1);
        $display("test threshold done");
        wb_wr(`DCB_ADR_CTRL, 32'h0000_0004);
        wb_wr(`DCB_ADR_LIM, 32'h0050_0200);
        wb_wr(`DCB_ADR_ALTLIM, 32'h0000_0100);
        for (int i = 0; i < 8; i++) begin
            r = (i == 2) ? 16'h0000 : 16'($random(seed)) & 16'h03ff;
            freq_ref <= r;
            alt_set <= i[0];
            third_set <= (i == 7);
            lo = i[0] ? 16'h0000 : 16'h0050;
            hi = i[0] ? 16'h0100 : 16'h0200;
            tick(6);
            check("limit", freq_cmd, (i == 7) ? r : (r > hi ? hi : (r < lo ? lo : r)));
        end
        third_set <= 1'b0;
        alt_set <= 1'b0;
        ref_bip <= 1'b1;
        ref_neg <= 1'b1;
        freq_ref <= 16'h0000;
        run_fw <= 1'b0;
        run_rv <= 1'b1;
        tick(6);
        check("bipolar floor", freq_cmd, 16'h0050);
        check("bipolar reverse", dir_rev, 1'b1);
        run_rv <= 1'b0;
        run_fw <= 1'b1;
        tick(6);
        check("bipolar forward", dir_rev, 1'b0);
        wb_wr(`DCB_ADR_CTRL, 32'h0000_001c);
        tick(6);
        check("panel reverse", dir_rev, 1'b1);
        check("panel floor", freq_cmd, 16'h0050);
        $display("test limits done");
        tick(5);
        stop_test();
    end
endmodule : dcb_brake_limit_tb
